// File: radio_interrupt_enable_clear.sv
`timescale 1ns/100ps
`include "rie_params.svh"

module radio_interrupt_enable_clear
  import rie_pkg::*;
#(
  parameter int BC_W = 16,  // Bit counter compare width
  parameter int SS_W = 7    // Signal strength sample width
) (
  input  wire logic            pclk,
  input  wire logic            presetn,
  // APB slave
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire rie_addr_t       paddr,
  input  wire rie_word_t       pwdata,
  output rie_word_t            prdata,
  output logic                 pready,
  output logic                 pslverr,
  // Radio event pulses, same clock
  input  wire logic            evt_ready,
  input  wire logic            evt_address,
  input  wire logic            evt_payload,
  input  wire logic            evt_end,
  input  wire logic            evt_disabled,
  input  wire logic            evt_device_address_match,
  input  wire logic            evt_device_address_miss,
  input  wire logic            evt_signal_strength_sample_done,
  input  wire logic            evt_checksum_pass,
  input  wire logic            evt_checksum_fail,
  // Strength sample delivered with its done pulse
  input  wire logic [SS_W-1:0] signal_strength_sample,
  // Receive bit counter
  input  wire logic            rx_bit_strobe,
  input  wire logic [BC_W-1:0] rx_bit_count,
  // Radio interrupt line
  output logic                 irq
);

  // Register state of the core
  typedef struct packed {
    rie_word_t       en_r;      // Shared interrupt enables
    logic [BC_W-1:0] bcc_r;     // Bit counter compare value
    logic [SS_W-1:0] sample_r;  // Latest strength sample
    logic            irq_r;     // Interrupt line
  } rie_core_s;

  rie_core_s st;             // Registered core state
  rie_core_s nxt;            // Next core state
  rie_word_t evt_vec;        // Events placed at their bit positions
  rie_word_t clr_vec;        // Write-one-to-clear strobes for flags
  rie_word_t flags_q;        // Sticky event flags
  rie_word_t rd_data;        // Read mux result
  logic      addr_hit;       // Address decodes to a register
  logic      wr_stb;         // Write takes effect this edge
  logic      bc_match;       // Bit counter reached compare value
  logic      wr_set;         // Write to enable set
  logic      wr_clear;       // Write to enable clear

  // Bus front end
  rie_apb_slave u_apb (
    .pclk     (pclk),
    .presetn  (presetn),
    .psel     (psel),
    .penable  (penable),
    .pwrite   (pwrite),
    .rd_data  (rd_data),
    .addr_hit (addr_hit),
    .prdata   (prdata),
    .pready   (pready),
    .pslverr  (pslverr),
    .wr_stb   (wr_stb)
  );

  // Sticky event flags
  rie_event_flags #(
    .N    (32),
    .MASK (`RIE_EVT_MASK)
  ) u_flags (
    .pclk    (pclk),
    .presetn (presetn),
    .evt     (evt_vec),
    .clr     (clr_vec),
    .flags   (flags_q)
  );

  // Match is a compare on the strobe, so a count that skips it is missed
  assign bc_match = rx_bit_strobe && (rx_bit_count == st.bcc_r);

  // Enable register strobes, live in the access cycle only
  assign wr_set   = wr_stb && (paddr == `RIE_OFS_EN_SET);
  assign wr_clear = wr_stb && (paddr == `RIE_OFS_EN_CLEAR);

  // Events onto the shared layout
  always_comb begin
    // Unused positions stay zero
    evt_vec                         = `RIE_WORD_ZERO;
    evt_vec[`RIE_BIT_READY]         = evt_ready;
    evt_vec[`RIE_BIT_ADDRESS]       = evt_address;
    evt_vec[`RIE_BIT_PAYLOAD]       = evt_payload;
    evt_vec[`RIE_BIT_END]           = evt_end;
    evt_vec[`RIE_BIT_DISABLED]      = evt_disabled;
    evt_vec[`RIE_BIT_DEV_MATCH]     = evt_device_address_match;
    evt_vec[`RIE_BIT_DEV_MISS]      = evt_device_address_miss;
    evt_vec[`RIE_BIT_SS_DONE]       = evt_signal_strength_sample_done;
    evt_vec[`RIE_BIT_BC_MATCH]      = bc_match;
    evt_vec[`RIE_BIT_CK_PASS]       = evt_checksum_pass;
    evt_vec[`RIE_BIT_CK_FAIL]       = evt_checksum_fail;
  end

  // Status flags clear by writing ones
  always_comb begin
    clr_vec = `RIE_WORD_ZERO;
    if (wr_stb && (paddr == `RIE_OFS_EVT_STATUS)) begin
      // Only implemented bits can be cleared
      clr_vec = pwdata & `RIE_EVT_MASK;
    end
  end

  // Address decode and read mux
  always_comb begin
    addr_hit = 1'b1;
    rd_data  = `RIE_WORD_ZERO;
    case (paddr)
      // Sticky flags as they stand
      `RIE_OFS_EVT_STATUS: begin
        rd_data = flags_q;
      end
      // Both enable registers show the same state
      `RIE_OFS_EN_SET, `RIE_OFS_EN_CLEAR: begin
        rd_data = st.en_r;
      end
      // Read only; upper bits read zero
      `RIE_OFS_SS_SAMPLE: begin
        rd_data[SS_W-1:0] = st.sample_r;
      end
      // Compare value in the low bits
      `RIE_OFS_BC_COMPARE: begin
        rd_data[BC_W-1:0] = st.bcc_r;
      end
      default: begin
        // Unmapped: error answer, zero data
        addr_hit = 1'b0;
      end
    endcase
  end

  // Next state of enables, compare value, sample and line
  always_comb begin
    // Hold everything by default
    nxt = st;
    // Set only touches written ones; zeros keep their bits
    if (wr_set) begin
      nxt.en_r = st.en_r | (pwdata & `RIE_EVT_MASK);
    end
    // Clear only touches written ones; zeros keep their bits
    if (wr_clear) begin
      nxt.en_r = st.en_r & ~pwdata;
    end
    // Compare value taken from the low data bits
    if (wr_stb && (paddr == `RIE_OFS_BC_COMPARE)) begin
      nxt.bcc_r = pwdata[BC_W-1:0];
    end
    // Sample held until the next done pulse
    if (evt_signal_strength_sample_done) begin
      nxt.sample_r = signal_strength_sample;
    end
    // Line follows flags one cycle later, a deliberate flop for timing
    nxt.irq_r = |(flags_q & st.en_r);
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // All enables off until software sets them
      st.en_r     <= `RIE_EN_RESET;
      st.bcc_r    <= '0;
      st.sample_r <= '0;
      st.irq_r    <= 1'b0;
    end else begin
      // Next state taken on every edge
      st <= nxt;
    end
  end

  // Line comes straight from its flop
  assign irq = st.irq_r;

  // Clearing the ready enable
  chk_clr_ready: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_clear && pwdata[`RIE_BIT_READY]) |=> !st.en_r[`RIE_BIT_READY])
    else $error("ready enable not cleared");

  // Clearing the address enable, checked against the previous write
  chk_clr_address: assert property (@(posedge pclk) disable iff (!presetn)
    ($past(wr_clear) && $past(pwdata[`RIE_BIT_ADDRESS])) |-> !st.en_r[`RIE_BIT_ADDRESS])
    else $error("address enable not cleared");

  // Clearing the payload enable
  chk_clr_payload: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_clear && pwdata[`RIE_BIT_PAYLOAD]) ##1 1'b1 |-> !st.en_r[`RIE_BIT_PAYLOAD])
    else $error("payload enable not cleared");

  // Clearing the end enable
  chk_clr_end: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_clear && pwdata[`RIE_BIT_END]) |=> !st.en_r[`RIE_BIT_END])
    else $error("end enable not cleared");

  // Clearing the disabled enable, and it falls if it was set
  chk_clr_disabled: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_clear && pwdata[`RIE_BIT_DISABLED] && st.en_r[`RIE_BIT_DISABLED])
      |=> $fell(st.en_r[`RIE_BIT_DISABLED]))
    else $error("disabled enable did not fall");

  // Clearing the match enable; read of the clear register then shows zero
  chk_clr_device_address_match: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_clear && pwdata[`RIE_BIT_DEV_MATCH]) ##1 (psel && !penable && !pwrite &&
      paddr == `RIE_OFS_EN_CLEAR) |=> !prdata[`RIE_BIT_DEV_MATCH])
    else $error("match enable read back set after clear");

  // Clearing the miss enable
  chk_clr_device_address_miss: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_clear && pwdata[`RIE_BIT_DEV_MISS]) |=> !st.en_r[`RIE_BIT_DEV_MISS])
    else $error("miss enable not cleared");

  // Done pulse captures the sample and raises its flag
  chk_sample_capture: assert property (@(posedge pclk) disable iff (!presetn)
    evt_signal_strength_sample_done |=>
      (st.sample_r == $past(signal_strength_sample)) && flags_q[`RIE_BIT_SS_DONE])
    else $error("strength sample not captured");

  // Count equal to compare value raises the match flag
  chk_bit_counter_match_flag: assert property (@(posedge pclk) disable iff (!presetn)
    (rx_bit_strobe && rx_bit_count == st.bcc_r) |=> flags_q[`RIE_BIT_BC_MATCH])
    else $error("bit counter match flag not raised");

  // Clearing the checksum pass enable
  chk_clr_pass: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_clear && pwdata[`RIE_BIT_CK_PASS]) |=> !st.en_r[`RIE_BIT_CK_PASS])
    else $error("checksum pass enable not cleared");

  // Clearing the checksum fail enable
  chk_clr_fail: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_clear && pwdata[`RIE_BIT_CK_FAIL]) |=> !st.en_r[`RIE_BIT_CK_FAIL])
    else $error("checksum fail enable not cleared");

  // Set register turns the ready enable on
  chk_set_enable: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_set && pwdata[`RIE_BIT_READY]) |=> st.en_r[`RIE_BIT_READY])
    else $error("ready enable not set");

  // Reading either enable register returns the shared state
  chk_read_mirror: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite &&
      (paddr == `RIE_OFS_EN_SET || paddr == `RIE_OFS_EN_CLEAR))
      |=> (prdata == $past(st.en_r)))
    else $error("enable read back differs from state");

  // Zero bits of a clear write leave enables alone
  chk_zero_keeps: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_clear && !pwdata[`RIE_BIT_END] && st.en_r[`RIE_BIT_END])
      |=> st.en_r[`RIE_BIT_END])
    else $error("enable lost on zero write");

  // Enabled flag raises the line within one cycle and it stays while held
  chk_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
    (|(flags_q & st.en_r)) |=> irq)
    else $error("interrupt line low with enabled flag");

  // No enabled flag means the line drops next cycle
  chk_irq_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    !(|(flags_q & st.en_r)) |=> !irq)
    else $error("interrupt line high without enabled flag");

  // Zero bits of a set write leave enables alone
  chk_set_keeps: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_set && !pwdata[`RIE_BIT_READY] && !st.en_r[`RIE_BIT_READY])
      |=> !st.en_r[`RIE_BIT_READY])
    else $error("enable raised by a zero set bit");

  // Unmapped setup answers with an error and zero data
  chk_addr_fault: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !addr_hit) |=> (pready && pslverr && prdata == `RIE_WORD_ZERO))
    else $error("unmapped access not refused");

  // Bus writes never reach the sample register
  chk_sample_ro: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_stb && paddr == `RIE_OFS_SS_SAMPLE && !evt_signal_strength_sample_done)
      |=> $stable(st.sample_r))
    else $error("sample register changed by a bus write");

endmodule

// File: rie_params.svh
`ifndef RIE_PARAMS_SVH
`define RIE_PARAMS_SVH

// Register byte offsets inside the radio window
`define RIE_OFS_EVT_STATUS  12'h300
`define RIE_OFS_EN_SET      12'h304
`define RIE_OFS_EN_CLEAR    12'h308
`define RIE_OFS_SS_SAMPLE   12'h548
`define RIE_OFS_BC_COMPARE  12'h560

// Event bit positions, shared by status, enable set and enable clear
`define RIE_BIT_READY       0
`define RIE_BIT_ADDRESS     1
`define RIE_BIT_PAYLOAD     2
`define RIE_BIT_END         3
`define RIE_BIT_DISABLED    4
`define RIE_BIT_DEV_MATCH   5
`define RIE_BIT_DEV_MISS    6
`define RIE_BIT_SS_DONE     7
`define RIE_BIT_BC_MATCH    10
`define RIE_BIT_CK_PASS     12
`define RIE_BIT_CK_FAIL     13

// Implemented event bits; all others read as zero
`define RIE_EVT_MASK        32'h0000_34ff

// Reset values
`define RIE_EN_RESET        32'h0000_0000
`define RIE_FLAG_RESET      32'h0000_0000
`define RIE_WORD_ZERO       32'h0000_0000

`endif

// File: rie_pkg.sv
package rie_pkg;

  // Bus data word
  typedef logic [31:0] rie_word_t;

  // Register byte address inside the radio window
  typedef logic [11:0] rie_addr_t;

  // Bus slave answer state
  typedef struct packed {
    rie_word_t prdata_r;   // Read data for the access phase
    logic      pready_r;   // Access phase completes
    logic      pslverr_r;  // Unmapped address
  } rie_apb_s;

endpackage

// File: rie_apb_slave.sv
`timescale 1ns/100ps
`include "rie_params.svh"

// APB slave front end: one wait-free access phase per transfer
module rie_apb_slave
  import rie_pkg::*;
(
  input  wire logic      pclk,
  input  wire logic      presetn,
  input  wire logic      psel,
  input  wire logic      penable,
  input  wire logic      pwrite,
  input  wire rie_word_t rd_data,
  input  wire logic      addr_hit,
  output rie_word_t      prdata,
  output logic           pready,
  output logic           pslverr,
  output logic           wr_stb
);

  rie_apb_s st;   // Registered answer
  rie_apb_s nxt;  // Next answer

  // Answer is prepared in setup so prdata, pready and pslverr come from flops
  always_comb begin
    nxt          = st;
    nxt.pready_r = 1'b0;
    if (psel && !penable) begin
      // Setup cycle: latch read data and decode result
      nxt.pready_r  = 1'b1;
      nxt.pslverr_r = !addr_hit;
      nxt.prdata_r  = (!pwrite && addr_hit) ? rd_data : `RIE_WORD_ZERO;
    end else if (psel && penable && st.pready_r) begin
      // Transfer done: drop the error flag
      nxt.pslverr_r = 1'b0;
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= nxt;
    end
  end

  assign prdata  = st.prdata_r;
  assign pready  = st.pready_r;
  assign pslverr = st.pslverr_r;
  // Writes to unmapped addresses are dropped here
  assign wr_stb  = psel && penable && pwrite && st.pready_r && !st.pslverr_r;

  // Ready stands exactly one cycle after each setup
  chk_pready_one_cycle: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable) |=> (pready ##1 !pready))
    else $error("pready not a single cycle after setup");

endmodule

// File: rie_event_flags.sv
`timescale 1ns/100ps
`include "rie_params.svh"

// Sticky event flags, write one to clear, set wins over clear
module rie_event_flags #(
  parameter int          N    = 32,
  parameter logic [31:0] MASK = `RIE_EVT_MASK
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [N-1:0] evt,
  input  wire logic [N-1:0] clr,
  output logic [N-1:0]      flags
);

  typedef struct packed {
    logic [N-1:0] flag_r;  // Sticky event bits
  } rie_flag_s;

  rie_flag_s    st;        // Registered flags
  rie_flag_s    nxt;       // Next flags
  logic [N-1:0] flag_calc; // Per-bit next value

  // Unimplemented bits stay zero so they can never raise the line
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_bit
      if (MASK[i]) begin : g_live
        // An event in the clearing cycle is kept
        assign flag_calc[i] = evt[i] | (st.flag_r[i] & ~clr[i]);
      end else begin : g_dead
        assign flag_calc[i] = 1'b0;
      end
    end
  endgenerate

  // Next state
  always_comb begin
    nxt        = st;
    nxt.flag_r = flag_calc;
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= nxt;
    end
  end

  assign flags = st.flag_r;

  // Event together with its clear still leaves the flag set
  chk_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
    (evt[0] && clr[0] && MASK[0]) |=> flags[0])
    else $error("event lost against a simultaneous clear");

endmodule

// File: test_radio_interrupt_enable_clear.sv
`timescale 1ns/100ps
`include "rie_params.svh"

// Self-checking bench for the radio interrupt enable block
module test_radio_interrupt_enable_clear
  import rie_pkg::*;
;
  logic        pclk;                    // Bus clock, 25 MHz
  logic        presetn;                 // Async reset, active low
  logic        psel;                    // APB select
  logic        penable;                 // APB access phase
  logic        pwrite;                  // APB direction
  rie_addr_t   paddr;                   // APB byte address
  rie_word_t   pwdata;                  // APB write data
  rie_word_t   prdata;                  // APB read data
  logic        pready;                  // APB completion
  logic        pslverr;                 // APB error
  logic [13:0] ev;                      // Event pulses by bit position
  logic [6:0]  signal_strength_sample;  // Sample delivered with done
  logic        rx_bit_strobe;           // Bit count valid
  logic [15:0] rx_bit_count;            // Received bit count
  logic        irq;                     // Radio interrupt line
  int          miscompares;             // Mismatches seen
  int          checks;                  // Comparisons made
  rie_word_t   en;                      // Expected enable state
  rie_word_t   stat;                    // Expected event flags
  rie_word_t   rd;                      // Last read data
  logic        er;                      // Last error answer
  bit          keep;                    // Next transfer follows at once
  bit          held;                    // psel left high by the last transfer
  int          bits [11] = '{0, 1, 2, 3, 4, 5, 6, 7, 10, 12, 13};

  radio_interrupt_enable_clear uut (
    .pclk                            (pclk),
    .presetn                         (presetn),
    .psel                            (psel),
    .penable                         (penable),
    .pwrite                          (pwrite),
    .paddr                           (paddr),
    .pwdata                          (pwdata),
    .prdata                          (prdata),
    .pready                          (pready),
    .pslverr                         (pslverr),
    .evt_ready                       (ev[`RIE_BIT_READY]),
    .evt_address                     (ev[`RIE_BIT_ADDRESS]),
    .evt_payload                     (ev[`RIE_BIT_PAYLOAD]),
    .evt_end                         (ev[`RIE_BIT_END]),
    .evt_disabled                    (ev[`RIE_BIT_DISABLED]),
    .evt_device_address_match        (ev[`RIE_BIT_DEV_MATCH]),
    .evt_device_address_miss         (ev[`RIE_BIT_DEV_MISS]),
    .evt_signal_strength_sample_done (ev[`RIE_BIT_SS_DONE]),
    .evt_checksum_pass               (ev[`RIE_BIT_CK_PASS]),
    .evt_checksum_fail               (ev[`RIE_BIT_CK_FAIL]),
    .signal_strength_sample          (signal_strength_sample),
    .rx_bit_strobe                   (rx_bit_strobe),
    .rx_bit_count                    (rx_bit_count),
    .irq                             (irq)
  );

  // Clock, 40 ns period
  always #20 pclk = ~pclk;

  // Compare and count
  task automatic chk(input rie_word_t seen, input rie_word_t exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One APB transfer; waits for pready, only the watchdog bounds it
  task automatic apb(input logic w, input rie_addr_t a, input rie_word_t d);
    // Back to back: setup starts in the edge that ended the last access
    if (!held) @(posedge pclk);
    held    = 1'b0;
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    // Answer taken at the edge where pready is seen high
    rd = prdata;
    er = pslverr;
    penable <= 1'b0;
    if (!keep) psel <= 1'b0;
    held = keep;
    keep = 1'b0;
  endtask

  // Read and compare, also expecting no error
  task automatic rd_chk(input rie_addr_t a, input rie_word_t exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
    chk({31'h0, er}, 32'h0000_0000);
  endtask

  // Check the interrupt line after it has settled
  task automatic irq_chk(input logic exp);
    repeat (2) @(posedge pclk);
    #1;
    chk({31'h0, irq}, {31'h0, exp});
  endtask

  // Raise one event, by pulse or by bit count match
  task automatic fire(input int b);
    @(posedge pclk);
    if (b == `RIE_BIT_BC_MATCH) begin
      rx_bit_strobe <= 1'b1;
      rx_bit_count  <= 16'h0005;
    end else begin
      ev <= 14'h0001 << b;
    end
    if (b == `RIE_BIT_SS_DONE) signal_strength_sample <= 7'h5a;
    @(posedge pclk);
    ev            <= '0;
    rx_bit_strobe <= 1'b0;
  endtask

  // Verdict and end of run
  task automatic test_done;
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Watchdog at 10000 cycles, far beyond the expected run of a few hundred cycles
  initial begin
    #400000;
    miscompares++;
    test_done;
  end

  // Main sequence
  initial begin
    pclk = 0;
    presetn = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = '0;
    pwdata = '0;
    ev = '0;
    signal_strength_sample = '0;
    rx_bit_strobe = 0;
    rx_bit_count = '0;
    miscompares = 0;
    checks = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    // Reset state of enables, flags and line
    rd_chk(`RIE_OFS_EN_CLEAR, `RIE_EN_RESET);
    rd_chk(`RIE_OFS_EVT_STATUS, `RIE_FLAG_RESET);
    chk({31'h0, irq}, 32'h0000_0000);
    // Set all; both views agree, unimplemented bits read zero
    apb(1'b1, `RIE_OFS_EN_SET, 32'hffff_ffff);
    rd_chk(`RIE_OFS_EN_CLEAR, `RIE_EVT_MASK);
    rd_chk(`RIE_OFS_EN_SET, `RIE_EVT_MASK);
    // Zero write is harmless
    apb(1'b1, `RIE_OFS_EN_CLEAR, `RIE_WORD_ZERO);
    rd_chk(`RIE_OFS_EN_CLEAR, `RIE_EVT_MASK);
    // Compare register, and a count that must not match
    apb(1'b1, `RIE_OFS_BC_COMPARE, 32'h0000_0005);
    rd_chk(`RIE_OFS_BC_COMPARE, 32'h0000_0005);
    @(posedge pclk);
    rx_bit_strobe <= 1'b1;
    rx_bit_count  <= 16'h0004;
    @(posedge pclk);
    rx_bit_strobe <= 1'b0;
    rd_chk(`RIE_OFS_EVT_STATUS, 32'h0000_0000);
    // Each event raises the line, then its clear bit drops it
    en   = `RIE_EVT_MASK;
    stat = '0;
    foreach (bits[i]) begin
      fire(bits[i]);
      irq_chk(1'b1);
      en   = en & ~(32'h1 << bits[i]);
      stat = stat | (32'h1 << bits[i]);
      // Clear, then read back in the very next setup
      keep = 1'b1;
      apb(1'b1, `RIE_OFS_EN_CLEAR, 32'h1 << bits[i]);
      rd_chk(`RIE_OFS_EN_CLEAR, en);
      irq_chk(1'b0);
      rd_chk(`RIE_OFS_EVT_STATUS, stat);
    end
    // Fresh sample readable; writes there are ignored
    apb(1'b1, `RIE_OFS_SS_SAMPLE, 32'h0000_0000);
    rd_chk(`RIE_OFS_SS_SAMPLE, 32'h0000_005a);
    apb(1'b1, `RIE_OFS_EVT_STATUS, 32'hffff_ffff);
    rd_chk(`RIE_OFS_EVT_STATUS, 32'h0000_0000);
    // Event sampled in the clearing edge survives the clear
    fork
      apb(1'b1, `RIE_OFS_EVT_STATUS, 32'h0000_0001);
      begin
        @(posedge pclk);
        fire(`RIE_BIT_READY);
      end
    join
    rd_chk(`RIE_OFS_EVT_STATUS, 32'h0000_0001);
    // Masked event stays quiet until enabled, then clears
    fire(`RIE_BIT_END);
    irq_chk(1'b0);
    apb(1'b1, `RIE_OFS_EN_SET, 32'h0000_0008);
    irq_chk(1'b1);
    rd_chk(`RIE_OFS_EN_CLEAR, 32'h0000_0008);
    apb(1'b1, `RIE_OFS_EVT_STATUS, 32'h0000_0008);
    irq_chk(1'b0);
    // Unmapped address: error, zero data, write dropped
    apb(1'b1, 12'h104, 32'hffff_ffff);
    chk({31'h0, er}, 32'h0000_0001);
    apb(1'b0, 12'h104, 32'h0000_0000);
    chk({31'h0, er}, 32'h0000_0001);
    chk(rd, 32'h0000_0000);
    rd_chk(`RIE_OFS_EN_CLEAR, 32'h0000_0008);
    // Last clear through the clear register
    apb(1'b1, `RIE_OFS_EN_CLEAR, 32'h0000_0008);
    rd_chk(`RIE_OFS_EN_SET, 32'h0000_0000);
    test_done;
  end
endmodule
